// ==== ivs_arbiter.sv ====
`timescale 1ns/1ps
`default_nettype none
// picks the winner among traps and enabled sources
module ivs_arbiter #(
    parameter int NSRC = 246,
    parameter int NTRP = 6
) (
    input  wire logic [NTRP-1:0]   trap_req,
    input  wire logic [NSRC-1:0]   src_req,
    input  wire logic [NSRC*3-1:0] src_prio,
    input  wire logic              global_irq_enable,
    input  wire logic [2:0]        cpu_level,
    output logic                   found,
    output logic                   is_trap,
    output logic [7:0]             vector,
    output logic [3:0]             level
);
    // lowest index wins on ties; scan from top so the last hit is the lowest
    always_comb begin
        found   = 1'b0;
        is_trap = 1'b0;
        vector  = 8'h00;
        level   = 4'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (global_irq_enable && src_req[i] && src_prio[i*3 +: 3] != ivs_pkg::PRIO_DISABLED
                && src_prio[i*3 +: 3] > cpu_level
                && ({1'b0, src_prio[i*3 +: 3]} >= level)) begin
                found   = 1'b1;
                vector  = 8'(i + NTRP);
                level   = {1'b0, src_prio[i*3 +: 3]};
            end
        end
        // traps stay live with gie low and outrank every level
        for (int t = NTRP - 1; t >= 0; t--) begin
            if (trap_req[t]) begin
                found   = 1'b1;
                is_trap = 1'b1;
                vector  = 8'(t);
                level   = ivs_pkg::TRAP_PRIO;
            end
        end
    end
endmodule : ivs_arbiter
`default_nettype wire

// ==== ivs_controller.sv ====
// Summary of operation
// - the primary vector table lives in program memory from address 000004h.
// - six trap vectors come first, then up to 246 source vectors, one per source.
// - each entry is a 24-bit program address, the start of that source's service routine.
// - natural priority follows table position, lower vector number wins, vector 0 beats all.
// - the alternate table needs a boot segment, the config permit, and control bit 8 set.
// - with the alternate table on, every interrupt and trap fetches from it.
// - the alternate table starts at the last page of the boot segment given by the 13-bit limit.
// - the alternate table is only enabled when the boot segment spans at least 2 pages.
// - both tables inherit the boot segment code protection.
// - reset clears the registers except control bit 15 and pc_force_zero, which reset to 1, and execution restarts at 0x000000 without a table fetch.
// - bit 13 reads 1 while any trap request is pending and 0 otherwise.
// - all peripheral request lines merge into one request to the core.
// - seven user priority levels, natural order decides within a level.
`timescale 1ns/1ps
`default_nettype none
module ivs_controller #(
    parameter int NSRC = ivs_pkg::NUM_SOURCES
) (
    input  wire logic                 mclk,
    input  wire logic                 rst,
    // register port
    input  wire logic [3:0]           reg_addr,
    input  wire logic [15:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [15:0]               reg_rdata,
    // configuration words from nonvolatile memory
    input  wire logic                 boot_segment_defined,
    input  wire logic                 alt_table_config_permit,
    input  wire logic [12:0]          boot_segment_limit,
    input  wire logic                 boot_code_protect,
    // sources
    input  wire logic [5:0]           trap_req,
    input  wire logic [NSRC-1:0]      src_req,
    input  wire logic [NSRC*3-1:0]    src_prio,
    // core side
    input  wire logic [2:0]           cpu_level,
    input  wire logic                 core_ack,
    input  wire logic                 core_return,
    input  wire logic                 core_reset,
    output ivs_pkg::ivs_req_t         core_req,
    output logic                      table_protect,
    output logic                      pc_force_zero,
    output logic                      irq_out
);
    typedef struct packed {
        ivs_pkg::ivs_state_t st;
        logic [15:0]         ctrl2;
        logic [15:0]         rdata;
        logic [15:0]         ev_status;
        logic [15:0]         ev_mask;
        ivs_pkg::ivs_req_t   req;
        logic                irq;
        logic                prot;
        logic                pcz;
    } ivs_state_s_t;

    ivs_state_s_t s_reg;
    ivs_state_s_t s_next;

    logic        arb_found;
    logic        arb_trap;
    logic [7:0]  arb_vec;
    logic [3:0]  arb_level;
    logic        alt_ok;
    logic [23:0] alt_base;
    logic [23:0] fetch_addr;
    logic [15:0] ev_set;

    ivs_arbiter #(
        .NSRC (NSRC),
        .NTRP (ivs_pkg::NUM_TRAPS)
    ) u_arb (
        .trap_req  (trap_req),
        .src_req   (src_req),
        .src_prio  (src_prio),
        .global_irq_enable       (s_reg.ctrl2[ivs_pkg::BIT_GIE]),
        .cpu_level (cpu_level),
        .found     (arb_found),
        .is_trap   (arb_trap),
        .vector    (arb_vec),
        .level     (arb_level)
    );

    // byte address of a table entry; entries are two byte-address units apart
    function automatic logic [23:0] entry_of(input logic [23:0] base, input logic [7:0] vec);
        entry_of = base + {15'h0000, vec, 1'b0};
    endfunction : entry_of

    // alternate table base is the start of the last boot page
    assign alt_base = 24'({boot_segment_limit - 13'h0001, 11'h000});
    // all three enables must hold and the segment must be at least two pages
    assign alt_ok = boot_segment_defined && alt_table_config_permit
                    && s_reg.ctrl2[ivs_pkg::BIT_ALT_SEL]
                    && (boot_segment_limit >= ivs_pkg::MIN_BOOT_PAGES);
    // select is sampled only when a new fetch is offered
    assign fetch_addr = alt_ok ? entry_of(alt_base, arb_vec)
                               : entry_of(ivs_pkg::PRIMARY_BASE, arb_vec);

    always_comb begin
        s_next = s_reg;
        ev_set = 16'h0000;
        s_next.rdata = 16'h0000;
        // software trap status mirrors any pending trap
        s_next.ctrl2[ivs_pkg::BIT_SOFT_TRAP_STATUS] = |trap_req;
        case (s_reg.st)
            ivs_pkg::IVS_IDLE: begin
                s_next.req.valid = 1'b0;
                if (arb_found) begin
                    s_next.st               = ivs_pkg::IVS_OFFER;
                    s_next.req.valid        = 1'b1;
                    s_next.req.is_trap      = arb_trap;
                    s_next.req.vector       = arb_vec;
                    s_next.req.level        = arb_level;
                    s_next.req.entry_addr   = fetch_addr;
                    s_next.req.alt          = alt_ok;
                end
            end
            ivs_pkg::IVS_OFFER: begin
                // held offer keeps its address even if the select flips
                if (core_ack) begin
                    s_next.st        = ivs_pkg::IVS_SERVICE;
                    s_next.req.valid = 1'b0;
                    ev_set[ivs_pkg::EV_TAKEN]     = 1'b1;
                    ev_set[ivs_pkg::EV_TRAP]      = s_reg.req.is_trap;
                    ev_set[ivs_pkg::EV_FETCH_ALT] = s_reg.req.alt;
                end
            end
            ivs_pkg::IVS_SERVICE: begin
                if (core_return) begin
                    s_next.st = ivs_pkg::IVS_IDLE;
                end
            end
            default: begin
                s_next.st = ivs_pkg::IVS_IDLE;
            end
        endcase
        // register writes
        if (reg_wr) begin
            case (reg_addr)
                ivs_pkg::ADDR_CTRL2: begin
                    s_next.ctrl2 = (reg_wdata & ivs_pkg::CTRL2_WMASK)
                                   | (s_next.ctrl2 & ~ivs_pkg::CTRL2_WMASK);
                end
                ivs_pkg::ADDR_IRQ_STATUS: begin
                    s_next.ev_status = s_reg.ev_status & ~reg_wdata;
                end
                ivs_pkg::ADDR_IRQ_MASK: begin
                    s_next.ev_mask = reg_wdata & ivs_pkg::EV_WMASK;
                end
                default: begin
                end
            endcase
        end
        // set beats a simultaneous clear
        s_next.ev_status = s_next.ev_status | ev_set;
        // register reads, answer in the following cycle
        if (reg_rd) begin
            case (reg_addr)
                ivs_pkg::ADDR_CTRL2:         s_next.rdata = s_reg.ctrl2;
                ivs_pkg::ADDR_PENDING:       s_next.rdata = {15'h0000, s_reg.req.valid};
                ivs_pkg::ADDR_VECTOR:        s_next.rdata = s_reg.req.entry_addr[15:0];
                ivs_pkg::ADDR_VEC_HI:        s_next.rdata = {s_reg.req.vector, s_reg.req.entry_addr[23:16]};
                ivs_pkg::ADDR_IRQ_STATUS:    s_next.rdata = s_reg.ev_status;
                ivs_pkg::ADDR_IRQ_MASK:      s_next.rdata = s_reg.ev_mask;
                ivs_pkg::ADDR_TABLE_BASE:    s_next.rdata = alt_ok ? alt_base[15:0] : ivs_pkg::PRIMARY_BASE[15:0];
                ivs_pkg::ADDR_TABLE_BASE_HI: s_next.rdata = {8'h00, alt_ok ? alt_base[23:16]
                                                                       : ivs_pkg::PRIMARY_BASE[23:16]};
                default:                     s_next.rdata = 16'h0000;
            endcase
        end
        s_next.irq  = |(s_next.ev_status & s_next.ev_mask);
        // both tables follow boot segment protection
        s_next.prot = boot_code_protect;
        s_next.pcz  = core_reset;
        // a device reset from the core side also clears state, offer, status and mask and reloads the control register
        if (core_reset) begin
            s_next.st        = ivs_pkg::IVS_IDLE;
            s_next.ctrl2     = ivs_pkg::CTRL2_RESET;
            s_next.ev_status = 16'h0000;
            s_next.ev_mask   = 16'h0000;
            s_next.req       = '0;
            s_next.irq       = 1'b0;
        end
    end

    // one register for all state
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_reg       <= '0;
            s_reg.st    <= ivs_pkg::IVS_IDLE;
            s_reg.ctrl2 <= ivs_pkg::CTRL2_RESET;
            s_reg.pcz   <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata     = s_reg.rdata;
    assign core_req      = s_reg.req;
    assign table_protect = s_reg.prot;
    assign pc_force_zero = s_reg.pcz;
    assign irq_out       = s_reg.irq;
endmodule : ivs_controller
`default_nettype wire

// ==== ivs_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// core: takes each offer after a delay, then returns after the same delay
module ivs_core_model (
    input wire logic              mclk,
    input wire logic              rst,
    input wire logic              slow,
    input wire ivs_pkg::ivs_req_t core_req,
    output logic                  core_ack,
    output logic                  core_return
);
    logic busy;
    int   cnt;
    // slow mode keeps an offer waiting long enough for register traffic
    always_ff @(posedge mclk) begin
        core_ack    <= 1'b0;
        core_return <= 1'b0;
        if (rst) begin
            busy <= 1'b0;
            cnt  <= 0;
        end else if (core_req.valid && !core_ack && !busy) begin
            cnt <= cnt + 1;
            // every entry fetched is taken as filled: software loads unused vectors with a reset handler
            if (cnt >= (slow ? 16 : 0)) begin
                core_ack <= 1'b1;
                busy     <= 1'b1;
                cnt      <= 0;
            end
        end else if (busy) begin
            cnt <= cnt + 1;
            if (cnt >= (slow ? 16 : 0)) begin
                core_return <= 1'b1;
                busy        <= 1'b0;
                cnt         <= 0;
            end
        end
    end
endmodule : ivs_core_model
`default_nettype wire

// ==== ivs_pkg.sv ====
`default_nettype none
package ivs_pkg;
    // register map on the plain register port
    localparam logic [3:0]  ADDR_CTRL2       = 4'h0;
    localparam logic [3:0]  ADDR_PENDING     = 4'h1;
    localparam logic [3:0]  ADDR_VECTOR      = 4'h2;
    localparam logic [3:0]  ADDR_VEC_HI      = 4'h3;
    localparam logic [3:0]  ADDR_IRQ_STATUS  = 4'h4;
    localparam logic [3:0]  ADDR_IRQ_MASK    = 4'h5;
    localparam logic [3:0]  ADDR_TABLE_BASE  = 4'h6;
    localparam logic [3:0]  ADDR_TABLE_BASE_HI = 4'h7;
    // control register fields
    localparam int          BIT_GIE          = 15;
    localparam int          BIT_SOFT_TRAP_STATUS       = 13;
    localparam int          BIT_ALT_SEL      = 8;
    localparam logic [15:0] CTRL2_RESET      = 16'h8000;
    // bit 13 is left out: it only follows the trap lines, software cannot fake it
    localparam logic [15:0] CTRL2_WMASK      = 16'h8117;
    // program memory layout
    localparam logic [23:0] PRIMARY_BASE     = 24'h000004;
    localparam logic [23:0] RESET_VECTOR     = 24'h000000;
    localparam int          NUM_TRAPS        = 6;
    localparam int          NUM_SOURCES      = 246;
    localparam int          NUM_VECTORS      = NUM_TRAPS + NUM_SOURCES;
    localparam int          VEC_W            = 8;
    localparam int          BOOT_SEGMENT_LIMIT_W          = 13;
    localparam logic [12:0] MIN_BOOT_PAGES   = 13'h0002;
    localparam int          PAGE_SHIFT       = 11;
    localparam int          PRIO_W           = 3;
    localparam logic [2:0]  PRIO_DISABLED    = 3'h0;
    localparam logic [3:0]  TRAP_PRIO        = 4'h8;
    // interrupt status bits
    localparam int          EV_TAKEN         = 0;
    localparam int          EV_TRAP          = 1;
    localparam int          EV_FETCH_ALT     = 2;
    localparam logic [15:0] EV_WMASK         = 16'h0007;

    // request toward the core
    typedef struct packed {
        logic        valid;
        logic        is_trap;
        logic [7:0]  vector;
        logic [3:0]  level;
        logic [23:0] entry_addr;
        logic        alt;
    } ivs_req_t;

    typedef enum logic [1:0] {IVS_IDLE, IVS_OFFER, IVS_SERVICE} ivs_state_t;
endpackage : ivs_pkg
`default_nettype wire

// ==== ivs_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
// port-level checks on the requests offered to the core, on table protection and on the reset program counter force
module ivs_sva #(
    parameter int NSRC = 246
) (
    input wire logic              mclk,
    input wire logic              rst,
    input wire logic              boot_segment_defined,
    input wire logic              alt_table_config_permit,
    input wire logic [12:0]       boot_segment_limit,
    input wire logic              boot_code_protect,
    input wire logic [2:0]        cpu_level,
    input wire logic              core_ack,
    input wire logic              core_reset,
    input wire ivs_pkg::ivs_req_t core_req,
    input wire logic              table_protect,
    input wire logic              pc_force_zero
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // one 24-bit entry per vector, two address units apart
    logic [23:0] off;
    logic [23:0] alt_base;
    assign off      = {15'h0, core_req.vector, 1'b0};
    assign alt_base = {boot_segment_limit - 13'h1, 11'h0};
    property p_prim; core_req.valid && !core_req.alt |-> core_req.entry_addr == 24'h000004 + off; endproperty
    property p_alt; core_req.valid && core_req.alt |-> core_req.entry_addr == alt_base + off; endproperty
    property p_gate; core_req.valid && core_req.alt |-> boot_segment_defined && alt_table_config_permit; endproperty
    property p_pages; core_req.valid && core_req.alt |-> boot_segment_limit >= 13'h2; endproperty
    property p_trap; core_req.valid |-> core_req.is_trap == (core_req.vector < 8'h6); endproperty
    property p_lvl; core_req.valid && !core_req.is_trap |-> core_req.level > {1'b0, cpu_level}; endproperty
    // an offer may not change under the core until it is taken
    property p_hold; core_req.valid && !core_ack |=> core_req.valid && $stable(core_req); endproperty
    property p_take; core_req.valid && core_ack |=> !core_req.valid ##1 !core_req.valid; endproperty
    property p_prot; $rose(boot_code_protect) |=> table_protect; endproperty
    property p_pc; core_reset |=> pc_force_zero; endproperty
    a_prim: assert property (p_prim) else $error("primary entry address wrong");
    a_alt: assert property (p_alt) else $error("alternate entry address wrong");
    a_gate: assert property (p_gate) else $error("alternate table used without permit");
    a_pages: assert property (p_pages) else $error("alternate table with short boot segment");
    a_trap: assert property (p_trap) else $error("trap flag does not match vector");
    a_lvl: assert property (p_lvl) else $error("source offered at or below core level");
    a_hold: assert property (p_hold) else $error("offer changed before acknowledge");
    a_take: assert property (p_take) else $error("offer not withdrawn after acknowledge");
    a_prot: assert property (p_prot) else $error("table protection not inherited");
    a_pc: assert property (p_pc) else $error("program counter not forced on reset");
    c_alt: cover property (core_req.valid && core_req.alt);
    c_trap: cover property (core_req.valid && core_req.is_trap);
    c_take: cover property (core_req.valid && core_ack);
endmodule : ivs_sva
bind ivs_controller ivs_sva #(.NSRC(NSRC)) ivs_sva_i (.mclk, .rst, .boot_segment_defined, .alt_table_config_permit,
    .boot_segment_limit, .boot_code_protect, .cpu_level, .core_ack, .core_reset, .core_req, .table_protect,
    .pc_force_zero);
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
    logic mclk, rst, reg_wr, reg_rd, core_ack, core_return, core_reset, slow, irq_out, table_protect, pc_force_zero;
    logic boot_segment_defined, alt_table_config_permit, boot_code_protect, global_irq_enable, alt_on;
    logic [3:0]   reg_addr;
    logic [15:0]  reg_wdata, reg_rdata, d;
    logic [12:0]  boot_segment_limit;
    logic [5:0]   trap_req, treq;
    logic [245:0] src_req, sreq;
    logic [737:0] src_prio, sprio;
    logic [2:0]   cpu_level;
    ivs_pkg::ivs_req_t core_req;
    int seed, mismatches, total_checks, k, j, idx, lvl;
    ivs_controller ivs_controller_i (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .boot_segment_defined, .alt_table_config_permit, .boot_segment_limit, .boot_code_protect, .trap_req, .src_req,
        .src_prio, .cpu_level, .core_ack, .core_return, .core_reset, .core_req, .table_protect, .pc_force_zero, .irq_out);
    ivs_core_model ivs_core_model_i (.mclk, .rst, .slow, .core_req, .core_ack, .core_return);
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report
    // one idle cycle after each strobe keeps drives one per time step
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
        @(posedge mclk); reg_wr <= 1'b0; @(posedge mclk);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge mclk); reg_rd <= 1'b0; #1;
        // read data stand only in the cycle after the strobe
        v = reg_rdata;
        @(posedge mclk);
    endtask : rd
    // reference winner: traps by index, then highest level above the core, lower index on a tie
    task automatic predict(output int v, output int l);
        v = -1; l = 0;
        for (int t = 5; t >= 0; t--) if (treq[t]) begin v = t; l = ivs_pkg::TRAP_PRIO; end
        if (v < 0 && global_irq_enable)
            for (int i = 0; i < 246; i++)
                if (sreq[i] && sprio[3*i+:3] > lvl && sprio[3*i+:3] > l) begin v = 6 + i; l = sprio[3*i+:3]; end
    endtask : predict
    task automatic service(input string nm);
        int v, l, n;
        logic [23:0] base, ent;
        logic [15:0] r;
        predict(v, l);
        base = alt_on ? {13'h3, 11'h0} : 24'h000004;
        ent = base + 24'(2 * v);
        src_req <= sreq; src_prio <= sprio; trap_req <= treq;
        n = 0;
        do begin @(posedge mclk); n++; end while (core_req.valid !== 1'b1 && n < 40);
        `CHK({nm, " offered"}, 1'b1, core_req.valid)
        `CHK({nm, " vector"}, v[7:0], core_req.vector)
        `CHK({nm, " level"}, l[3:0], core_req.level)
        `CHK({nm, " trap"}, (v < 6), core_req.is_trap)
        `CHK({nm, " entry"}, ent, core_req.entry_addr)
        `CHK({nm, " alt"}, alt_on, core_req.alt)
        // a slow core leaves the offer standing long enough to read its register view back
        if (slow) begin
            rd(ivs_pkg::ADDR_PENDING, r); `CHK({nm, " pending"}, 16'h0001, r)
            rd(ivs_pkg::ADDR_VECTOR, r); `CHK({nm, " addr lo"}, ent[15:0], r)
            rd(ivs_pkg::ADDR_VEC_HI, r); `CHK({nm, " addr hi"}, {v[7:0], ent[23:16]}, r)
            rd(ivs_pkg::ADDR_TABLE_BASE, r); `CHK({nm, " base"}, base[15:0], r)
        end
        do begin @(posedge mclk); n++; end while (core_ack !== 1'b1 && n < 60);
        src_req <= '0; trap_req <= 6'h0;
        do begin @(posedge mclk); n++; end while (core_return !== 1'b1 && n < 90);
        `CHK({nm, " served"}, 1'b1, core_return)
        @(posedge mclk);
    endtask : service
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        final_report();
    end
    initial begin
        seed = 94; mismatches = 0; total_checks = 0; rst = 1'b1; reg_addr = 4'h0; reg_wdata = 16'h0;
        reg_wr = 1'b0; reg_rd = 1'b0; core_reset = 1'b0; slow = 1'b0; boot_segment_defined = 1'b1;
        alt_table_config_permit = 1'b1; boot_segment_limit = 13'h4; boot_code_protect = 1'b0; trap_req = 6'h0;
        src_req = '0; src_prio = '0; cpu_level = 3'h0; treq = 6'h0; sreq = '0; sprio = '0; global_irq_enable = 1'b1; alt_on = 1'b0;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(ivs_pkg::ADDR_CTRL2, d); `CHK("ctrl2 reset", 16'h8000, d)
        rd(4'hf, d); `CHK("unmapped", 16'h0, d)
        $display("reset test done");
        wr(ivs_pkg::ADDR_IRQ_MASK, 16'h0001);
        for (k = 0; k < 12; k++) begin
            slow <= k[0];
            lvl = $unsigned($random(seed)) % 4; cpu_level <= lvl[2:0];
            sreq = '0;
            for (j = 0; j < 3; j++) begin
                idx = $unsigned($random(seed)) % 246; sreq[idx] = 1'b1;
                sprio[3*idx+:3] = (j == 0) ? 3'h7 : 3'($unsigned($random(seed)) % 8);
            end
            service("random");
        end
        `CHK("irq set", 1'b1, irq_out)
        wr(ivs_pkg::ADDR_IRQ_MASK, 16'h0000); @(posedge mclk); `CHK("irq masked", 1'b0, irq_out)
        wr(ivs_pkg::ADDR_IRQ_STATUS, 16'h0007); rd(ivs_pkg::ADDR_IRQ_STATUS, d); `CHK("status", 16'h0, d)
        $display("priority test done");
        lvl = 0; cpu_level <= 3'h0; slow <= 1'b1;
        wr(ivs_pkg::ADDR_CTRL2, 16'h0000); global_irq_enable = 1'b0;
        sreq = '0; sreq[10] = 1'b1; sprio[30+:3] = 3'h7; treq = 6'b010100;
        trap_req <= treq; repeat (2) @(posedge mclk);
        rd(ivs_pkg::ADDR_CTRL2, d); `CHK("trap status", 16'h2000, d)
        service("trap"); treq = 6'h0;
        src_req <= sreq; repeat (10) @(posedge mclk); `CHK("blocked", 1'b0, core_req.valid)
        wr(ivs_pkg::ADDR_CTRL2, 16'h8000); global_irq_enable = 1'b1;
        rd(ivs_pkg::ADDR_CTRL2, d); `CHK("trap idle", 16'h8000, d)
        service("unblocked");
        $display("trap test done");
        wr(ivs_pkg::ADDR_CTRL2, 16'h8100); slow <= 1'b1;
        sreq = '0; sreq[200] = 1'b1; sprio[600+:3] = 3'h5;
        for (k = 0; k < 4; k++) begin
            if (k == 3) wr(ivs_pkg::ADDR_CTRL2, 16'h8000);
            boot_segment_limit <= (k == 1) ? 13'h1 : 13'h4; boot_segment_defined <= (k != 2); alt_on = (k == 0);
            service("alt");
        end
        $display("alternate table test done");
        core_reset <= 1'b1; boot_code_protect <= 1'b1; repeat (2) @(posedge mclk);
        `CHK("pc zero", 1'b1, pc_force_zero)
        `CHK("protect", 1'b1, table_protect)
        core_reset <= 1'b0; repeat (2) @(posedge mclk); `CHK("pc run", 1'b0, pc_force_zero)
        $display("device reset test done");
        final_report();
    end
endmodule : testbench
`default_nettype wire
